// [shared/asc_defs.svh]
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// Clock period of core_clk.
`define ASC_CLK_PERIOD_NS     10

// Read cycle and operation recovery, minimum, per grade.
`define ASC_READ_CYCLE_FAST   70
`define ASC_READ_CYCLE_SLOW   85
// Chip select and output enable access, maximum.
`define ASC_CS_ACCESS_FAST    70
`define ASC_CS_ACCESS_SLOW    85
`define ASC_OE_ACCESS_FAST    35
`define ASC_OE_ACCESS_SLOW    45
// Deselect or strobe to float, maximum.
`define ASC_FLOAT_FAST        30
`define ASC_FLOAT_SLOW        35
// Write timing minimums.
`define ASC_CS_TO_END_FAST    60
`define ASC_CS_TO_END_SLOW    75
`define ASC_WRITE_PULSE_FAST  50
`define ASC_WRITE_PULSE_SLOW  55
`define ASC_DATA_OVERLAP_FAST 30
`define ASC_DATA_OVERLAP_SLOW 35
`define ASC_WRITE_CYCLE_FAST  70
`define ASC_WRITE_CYCLE_SLOW  85
// Deselect to retention.
`define ASC_DESELECT_TO_RET   0

`endif

// [shared/asc_pkg.sv]
package asc_pkg;

	typedef enum logic [2:0] {
		ASC_IDLE    = 3'b000,
		ASC_READ    = 3'b001,
		ASC_WRITE   = 3'b010,
		ASC_WR_HOLD = 3'b011,
		ASC_TURN    = 3'b100,
		ASC_RETAIN  = 3'b101,
		ASC_WAKE    = 3'b110
	} asc_state_t;

endpackage : asc_pkg

// [rtl/asc_timer.sv]
module asc_timer #(
	parameter int CNT_W = 4
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_val,
	output logic                  zero
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} asc_tmr_t;

	asc_tmr_t st_r;
	asc_tmr_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (load) begin
			st_nxt.cnt = load_val;
		end else if (st_r.cnt != '0) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign zero = (st_r.cnt == '0);

endmodule : asc_timer

// [rtl/asc_ctrl.sv]
`include "asc_defs.svh"

// Operation
// (R1) Memory stores data only while chip select and write strobe are both low.
// (R2) A write starts at the later falling edge of chip select or strobe.
// (R3) A write ends at the earlier rising edge; data latched there.
// (R4) Chip select falling with or after the strobe keeps data pins floating.
// (R5) With output enable low, write pulse covers data overlap plus strobe float.
// (R6) Never drive opposite data while the memory still drives the pins.
// (R7) Consecutive read cycles spaced at least 70 ns or 85 ns apart.
// (R8) Read data valid at most 70 ns or 85 ns after chip select.
// (R9) Read data valid at most 35 ns or 45 ns after output enable.
// (R10) Outputs float at most 30 ns or 35 ns after deselect.
// (R11) Old read data holds at least 10 ns after an address change.
// (R12) Chip select low at least 60 ns or 75 ns before write end.
// (R13) Write data valid at least 30 ns or 35 ns before write end.
// (R14) Chip select gates address, strobe, enable and data input buffers.
// (R15) In retention, lines may float while chip select stays high.
// (R16) Retention may start right after deselect; no delay needed.
// (R17) Strobe high through reads; one read cycle of recovery after retention.
module asc_ctrl #(
	parameter int ADDR_W     = 19,
	parameter int DATA_W     = 8,
	parameter bit SLOW_GRADE = 1'b0,
	parameter int CNT_W      = 4
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              req,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	input  wire logic              ret_req,
	output logic                   ready_r,
	output logic                   rd_valid_r,
	output logic [DATA_W-1:0]      rd_data_r,
	output logic                   ret_active_r,
	output logic                   mem_cs_n_r,
	output logic                   mem_we_n_r,
	output logic                   mem_oe_n_r,
	output logic [ADDR_W-1:0]      mem_addr_r,
	output logic                   ctl_oe_r,
	output logic [DATA_W-1:0]      dq_out_r,
	output logic                   dq_oe_r,
	input  wire logic [DATA_W-1:0] dq_in
);

	function automatic int ceil_cycles(input int ns);
		int c;
		c = (ns + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ceil_cycles

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : max2

	localparam int RC_NS  = SLOW_GRADE ? `ASC_READ_CYCLE_SLOW : `ASC_READ_CYCLE_FAST;
	localparam int CO_NS  = SLOW_GRADE ? `ASC_CS_ACCESS_SLOW : `ASC_CS_ACCESS_FAST;
	localparam int OE_NS  = SLOW_GRADE ? `ASC_OE_ACCESS_SLOW : `ASC_OE_ACCESS_FAST;
	localparam int HZ_NS  = SLOW_GRADE ? `ASC_FLOAT_SLOW : `ASC_FLOAT_FAST;
	localparam int CW_NS  = SLOW_GRADE ? `ASC_CS_TO_END_SLOW : `ASC_CS_TO_END_FAST;
	localparam int WP_NS  = SLOW_GRADE ? `ASC_WRITE_PULSE_SLOW : `ASC_WRITE_PULSE_FAST;
	localparam int DW_NS  = SLOW_GRADE ? `ASC_DATA_OVERLAP_SLOW : `ASC_DATA_OVERLAP_FAST;
	localparam int WC_NS  = SLOW_GRADE ? `ASC_WRITE_CYCLE_SLOW : `ASC_WRITE_CYCLE_FAST;

	// Read strobe phase covers cycle time and both access times.
	localparam int RD_CYC = max2(ceil_cycles(RC_NS), max2(ceil_cycles(CO_NS),
		ceil_cycles(OE_NS)));
	// Float wait after deselect, also used as write recovery padding.
	localparam int HZ_CYC = ceil_cycles(HZ_NS);
	// Write pulse meets chip select width, pulse width and the contention bound.
	localparam int WP_CYC = max2(ceil_cycles(CW_NS), max2(ceil_cycles(WP_NS),
		ceil_cycles(DW_NS + HZ_NS)));
	localparam int WR_TURN = max2(HZ_CYC, ceil_cycles(WC_NS) - WP_CYC - 1);
	localparam int RC_CYC = ceil_cycles(RC_NS);

	if (ADDR_W < 1 || DATA_W < 1) begin : g_chk_width
		$error("asc_ctrl: address and data widths must be positive");
	end
	if (max2(RD_CYC, max2(WP_CYC, max2(WR_TURN, RC_CYC))) >= (1 << CNT_W)) begin : g_chk_cnt
		$error("asc_ctrl: CNT_W too narrow for the timing counts");
	end

	typedef struct packed {
		asc_pkg::asc_state_t state;
		logic                ready;
		logic                rd_valid;
		logic [DATA_W-1:0]   rd_data;
		logic                ret_active;
		logic                cs_n;
		logic                we_n;
		logic                oe_n;
		logic [ADDR_W-1:0]   addr;
		logic                ctl_oe;
		logic [DATA_W-1:0]   dq_out;
		logic                dq_oe;
	} asc_ctl_t;

	asc_ctl_t         st_r;
	asc_ctl_t         st_nxt;
	logic             tmr_load;
	logic [CNT_W-1:0] tmr_val;
	logic             tmr_zero;

	asc_timer #(
		.CNT_W (CNT_W)
	) u_timer (
		.core_clk (core_clk),
		.reset    (reset),
		.load     (tmr_load),
		.load_val (tmr_val),
		.zero     (tmr_zero)
	);

	always_comb begin
		st_nxt          = st_r;
		st_nxt.rd_valid = 1'b0;
		tmr_load        = 1'b0;
		tmr_val         = '0;
		case (st_r.state)
			asc_pkg::ASC_IDLE: begin
				// Retention wins over a pending access so a sleep request is never starved.
				if (ret_req) begin
					st_nxt.state      = asc_pkg::ASC_RETAIN; // [R16]
					st_nxt.ready      = 1'b0;
					st_nxt.ret_active = 1'b1;
					st_nxt.cs_n       = 1'b1; // [R15]
					st_nxt.ctl_oe     = 1'b0; // [R15]
					st_nxt.dq_oe      = 1'b0;
				end else if (req) begin
					st_nxt.ready  = 1'b0;
					st_nxt.addr   = req_addr;
					st_nxt.cs_n   = 1'b0; // [R14]
					if (req_write) begin
						// Strobe and select fall together; output enable stays high.
						st_nxt.state  = asc_pkg::ASC_WRITE;
						st_nxt.we_n   = 1'b0; // [R2] [R4]
						st_nxt.oe_n   = 1'b1; // [R5] [R6]
						st_nxt.dq_out = req_wdata; // [R13]
						st_nxt.dq_oe  = 1'b1;
						tmr_load      = 1'b1;
						tmr_val       = CNT_W'(WP_CYC - 1); // [R1] [R5] [R12] [R13]
					end else begin
						st_nxt.state = asc_pkg::ASC_READ;
						st_nxt.we_n  = 1'b1; // [R17]
						st_nxt.oe_n  = 1'b0;
						st_nxt.dq_oe = 1'b0;
						tmr_load     = 1'b1;
						tmr_val      = CNT_W'(RD_CYC - 1); // [R7] [R8] [R9]
					end
				end
			end
			asc_pkg::ASC_READ: begin
				if (tmr_zero) begin
					// Sampled before deselect; the address is still stable here.
					st_nxt.rd_data  = dq_in; // [R8] [R9] [R11]
					st_nxt.rd_valid = 1'b1;
					st_nxt.cs_n     = 1'b1;
					st_nxt.oe_n     = 1'b1;
					st_nxt.state    = asc_pkg::ASC_TURN;
					tmr_load        = 1'b1;
					tmr_val         = CNT_W'(HZ_CYC - 1); // [R10] [R6]
				end
			end
			asc_pkg::ASC_WRITE: begin
				if (tmr_zero) begin
					// Both rise together, so the end of write is this single edge.
					st_nxt.cs_n  = 1'b1; // [R3]
					st_nxt.we_n  = 1'b1; // [R3]
					st_nxt.state = asc_pkg::ASC_WR_HOLD;
				end
			end
			asc_pkg::ASC_WR_HOLD: begin
				// Data held one cycle past the ending edge for board skew margin.
				st_nxt.dq_oe = 1'b0; // [R13]
				st_nxt.state = asc_pkg::ASC_TURN;
				tmr_load     = 1'b1;
				tmr_val      = CNT_W'(WR_TURN - 1);
			end
			asc_pkg::ASC_TURN: begin
				if (tmr_zero) begin
					st_nxt.state = asc_pkg::ASC_IDLE;
					st_nxt.ready = 1'b1;
				end
			end
			asc_pkg::ASC_RETAIN: begin
				if (!ret_req) begin
					st_nxt.state  = asc_pkg::ASC_WAKE;
					st_nxt.ctl_oe = 1'b1;
					st_nxt.we_n   = 1'b1;
					st_nxt.oe_n   = 1'b1;
					tmr_load      = 1'b1;
					tmr_val       = CNT_W'(RC_CYC - 1); // [R17]
				end
			end
			asc_pkg::ASC_WAKE: begin
				if (tmr_zero) begin
					st_nxt.state      = asc_pkg::ASC_IDLE;
					st_nxt.ret_active = 1'b0;
					st_nxt.ready      = 1'b1;
				end
			end
			default: begin
				st_nxt.state = asc_pkg::ASC_IDLE;
				st_nxt.cs_n  = 1'b1;
				st_nxt.dq_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_r            <= '0;
			st_r.state      <= asc_pkg::ASC_IDLE;
			st_r.ready      <= 1'b1;
			st_r.cs_n       <= 1'b1;
			st_r.we_n       <= 1'b1;
			st_r.oe_n       <= 1'b1;
			st_r.ctl_oe     <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ready_r      = st_r.ready;
	assign rd_valid_r   = st_r.rd_valid;
	assign rd_data_r    = st_r.rd_data;
	assign ret_active_r = st_r.ret_active;
	assign mem_cs_n_r   = st_r.cs_n;
	assign mem_we_n_r   = st_r.we_n;
	assign mem_oe_n_r   = st_r.oe_n;
	assign mem_addr_r   = st_r.addr;
	assign ctl_oe_r     = st_r.ctl_oe;
	assign dq_out_r     = st_r.dq_out;
	assign dq_oe_r      = st_r.dq_oe;

endmodule : asc_ctrl

// [test/asc_sram_model.sv]
`include "asc_defs.svh"

module asc_sram_model (
	input  wire logic        core_clk,
	input  wire logic        cs_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [18:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wdata_oe,
	output logic      [7:0]  rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem_r [0:255];
	// Data shows only at the end of the access window, so an early sample reads garbage.
	localparam int ACC_CYC = `ASC_CS_ACCESS_FAST / `ASC_CLK_PERIOD_NS - 1;
	logic [7:0] last_r;
	logic [3:0] sel_cnt_r;
	// Data is taken on every overlap cycle, so the value kept is the one at the end.
	always_ff @(posedge core_clk) begin
		if (!cs_n && !we_n && wdata_oe) begin
			mem_r[addr[7:0]] <= wdata;
		end
		last_r <= rdata;
		if (!cs_n && !oe_n && we_n) begin
			if (sel_cnt_r != 4'hf) begin
				sel_cnt_r <= sel_cnt_r + 4'h1;
			end
		end else begin
			sel_cnt_r <= 4'h0;
		end
	end
	// A floating bus shows the inverse of the last value, never a stale copy.
	assign rdata = (!cs_n && !oe_n && we_n && sel_cnt_r >= 4'(ACC_CYC)) ?
		mem_r[addr[7:0]] : ~last_r;
endmodule : asc_sram_model

// [test/asc_ctrl_checker.sv]
module asc_ctrl_checker #(
	parameter int DATA_W = 8
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              ready_r,
	input  wire logic              rd_valid_r,
	input  wire logic              ret_active_r,
	input  wire logic              mem_cs_n_r,
	input  wire logic              mem_we_n_r,
	input  wire logic              mem_oe_n_r,
	input  wire logic              ctl_oe_r,
	input  wire logic [DATA_W-1:0] dq_out_r,
	input  wire logic              dq_oe_r
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_we_hi; !mem_cs_n_r && !mem_oe_n_r |-> mem_we_n_r; endproperty
	property p_cs_min; $fell(mem_cs_n_r) |-> (!mem_cs_n_r)[*6]; endproperty
	property p_dat_st; !mem_we_n_r && !$past(mem_we_n_r) |-> dq_oe_r && $stable(dq_out_r); endproperty
	property p_dat_hd; $rose(mem_we_n_r) |-> dq_oe_r && $stable(dq_out_r); endproperty
	property p_no_fight; dq_oe_r |-> mem_oe_n_r; endproperty
	property p_turn; $rose(mem_cs_n_r) |-> mem_cs_n_r[*3]; endproperty
	property p_ret_cs; ret_active_r |-> mem_cs_n_r; endproperty
	property p_wake; $rose(ctl_oe_r) |-> (mem_cs_n_r && !ready_r)[*7]; endproperty
	a_we_hi: assert property (p_we_hi) else $error("strobe low in read");
	a_cs_min: assert property (p_cs_min) else $error("select too short");
	a_dat_st: assert property (p_dat_st) else $error("data moved in write");
	a_dat_hd: assert property (p_dat_hd) else $error("data not held");
	a_no_fight: assert property (p_no_fight) else $error("bus contention");
	a_turn: assert property (p_turn) else $error("cycle spacing short");
	a_ret_cs: assert property (p_ret_cs) else $error("select in retention");
	a_wake: assert property (p_wake) else $error("wake recovery short");
	c_rd: cover property (rd_valid_r);
	c_wr: cover property ($rose(mem_we_n_r));
	c_ret: cover property ($fell(ret_active_r));
endmodule : asc_ctrl_checker

bind asc_ctrl asc_ctrl_checker #(.DATA_W(DATA_W)) u_chk (
	.core_clk(core_clk), .reset(reset), .ready_r(ready_r), .rd_valid_r(rd_valid_r),
	.ret_active_r(ret_active_r), .mem_cs_n_r(mem_cs_n_r), .mem_we_n_r(mem_we_n_r),
	.mem_oe_n_r(mem_oe_n_r), .ctl_oe_r(ctl_oe_r), .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r)
);

// [test/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk, reset, req, req_write, ret_req, ready_r, rd_valid_r, ret_active_r;
	logic        mem_cs_n_r, mem_we_n_r, mem_oe_n_r, ctl_oe_r, dq_oe_r;
	logic [18:0] req_addr, mem_addr_r;
	logic [7:0]  req_wdata, rd_data_r, dq_out_r, dq_in;
	int          error_cnt, n_compared, t_val, t_rdy;

	asc_ctrl dut (
		.core_clk(core_clk), .reset(reset), .req(req), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .ret_req(ret_req), .ready_r(ready_r),
		.rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .ret_active_r(ret_active_r),
		.mem_cs_n_r(mem_cs_n_r), .mem_we_n_r(mem_we_n_r), .mem_oe_n_r(mem_oe_n_r),
		.mem_addr_r(mem_addr_r), .ctl_oe_r(ctl_oe_r), .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r),
		.dq_in(dq_in)
	);
	asc_sram_model u_mem (
		.core_clk(core_clk), .cs_n(mem_cs_n_r), .we_n(mem_we_n_r), .oe_n(mem_oe_n_r),
		.addr(mem_addr_r), .wdata(dq_out_r), .wdata_oe(dq_oe_r), .rdata(dq_in)
	);

	task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// The request stays up with other values while busy; it must be ignored.
	task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d);
		req = 1'b1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		@(posedge core_clk);
		#1;
		req_write = ~wr;
		req_addr = ~a;
		req_wdata = ~d;
		t_val = 0;
		t_rdy = 0;
		for (int n = 1; n < 40 && t_rdy == 0; n++) begin
			@(posedge core_clk);
			#1;
			if (n == 3) begin
				chk("mem_addr_r", a, mem_addr_r);
				req = 1'b0;
			end
			if (rd_valid_r === 1'b1) t_val = n;
			if (ready_r === 1'b1) t_rdy = n;
		end
	endtask : access

	task automatic wr(input logic [18:0] a, input logic [7:0] d);
		access(1'b1, a, d);
		chk("write ready", 10, t_rdy);
		chk("write valid", 0, t_val);
	endtask : wr

	task automatic rd(input logic [18:0] a, input logic [7:0] exp);
		access(1'b0, a, 8'h00);
		chk("read valid", 7, t_val);
		chk("read ready", 10, t_rdy);
		chk("rd_data_r", exp, rd_data_r);
	endtask : rd

	task automatic t_edges;
		wr(19'h0_0000, 8'ha5);
		wr(19'h7_ffff, 8'h5a);
		rd(19'h0_0000, 8'ha5);
		rd(19'h7_ffff, 8'h5a);
	endtask : t_edges

	task automatic t_overwrite;
		wr(19'h0_0012, 8'h3c);
		wr(19'h0_0012, 8'hc3);
		rd(19'h0_0012, 8'hc3);
	endtask : t_overwrite

	// Retention wins over a request presented on the same edge.
	task automatic t_retain;
		int n;
		ret_req = 1'b1;
		req = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		req = 1'b0;
		chk("ret_active_r", 1, ret_active_r);
		chk("ctl_oe_r", 0, ctl_oe_r);
		chk("mem_cs_n_r", 1, mem_cs_n_r);
		repeat (4) @(posedge core_clk);
		#1;
		ret_req = 1'b0;
		for (n = 0; n < 40 && ready_r !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		chk("wake cycles", 8, n);
		chk("ret end", 0, ret_active_r);
		rd(19'h0_0012, 8'hc3);
	endtask : t_retain

	task automatic wrap_up;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Whole run needs under 200 cycles; 20 us is ample.
	initial begin
		#20000;
		error_cnt++;
		wrap_up();
	end

	initial begin
		{reset, req, req_write, ret_req} = 4'h8;
		req_addr = 19'h0_0000;
		req_wdata = 8'h00;
		repeat (6) @(posedge core_clk);
		#1;
		reset = 1'b0;
		t_edges();
		t_overwrite();
		t_retain();
		wrap_up();
	end
endmodule : tb
